// ---- rtl/bit_timing_if.sv ----
// timing configuration carried from the register file to the sampler
`timescale 1ns/1ps
`default_nettype none
interface bit_timing_if;
	logic majority; // three-sample vote wanted
	logic [3:0] phase1; // phase one field
	logic [2:0] phase2; // phase two field
	logic hold; // sampler kept idle
	modport src (output majority, phase1, phase2, hold);
	modport dst (input majority, phase1, phase2, hold);
endinterface : bit_timing_if
`default_nettype wire

// ---- rtl/can_bit_sampler.sv ----
// per-bit quantum counter and sample voter
`timescale 1ns/1ps
`default_nettype none
module can_bit_sampler (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// configuration
	bit_timing_if.dst cfg,
	// bus side
	input wire logic tq_tick_i,
	input wire logic can_rx_i,
	// decided bit
	output logic bit_o,
	output logic bit_valid_o
);
	logic [4:0] tq_cnt; // quantum index inside the bit
	logic [1:0] hist; // two previous quantum samples
	logic [4:0] sample_at; // last quantum of phase one
	logic [4:0] bit_end; // last quantum of the bit
	logic vote; // majority of three samples

	// ------------------------------------------------------------
	// bit layout
	// ------------------------------------------------------------
	// phase one span: sync quantum 0, then field plus one quanta
	assign sample_at = {1'b0, cfg.phase1} + 5'h01;
	// phase two span; bit equals total quanta times tick period
	assign bit_end = sample_at + {2'h0, cfg.phase2} + 5'h01;
	// vote over sample point and two before
	assign vote = (hist[0] & hist[1]) | (hist[0] & can_rx_i) | (hist[1] & can_rx_i);

	// quantum counter, wraps at the end of each bit
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tq_cnt <= 5'h00;
		end else if (cfg.hold) begin
			tq_cnt <= 5'h00;
		end else if (tq_tick_i) begin
			tq_cnt <= (tq_cnt == bit_end) ? 5'h00 : tq_cnt + 5'h01;
		end
	end

	// history of quantum samples for the vote
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hist <= 2'h3;
		end else if (tq_tick_i) begin
			hist <= {hist[0], can_rx_i};
		end
	end

	// bit decision at the sample point
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bit_o <= 1'b1;
			bit_valid_o <= 1'b0;
		end else begin
			bit_valid_o <= tq_tick_i && !cfg.hold && (tq_cnt == sample_at);
			if (tq_tick_i && !cfg.hold && (tq_cnt == sample_at)) begin
				// single sample when vote is off
				bit_o <= cfg.majority ? vote : can_rx_i;
			end
		end
	end
endmodule : can_bit_sampler
`default_nettype wire

// ---- rtl/can_bit_timing_rx_status.sv ----
// bit timing and receiver status registers with an AXI4-Lite slave
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module can_bit_timing_rx_status (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// can bus and quantum tick
	input wire logic can_rx_i,
	input wire logic tq_tick_i,
	// controller state and events
	input wire logic sleep_mode_i,
	input wire logic bus_activity_i,
	input wire logic [7:0] rx_error_count_i,
	input wire logic [8:0] tx_error_count_i,
	input wire logic overrun_i,
	input wire logic msg_received_i,
	// outputs to the controller
	output logic soft_reset_o,
	output logic bus_off_o,
	output logic rx_swap_o,
	output logic rx_bit_o,
	output logic rx_bit_valid_o,
	// interrupt requests
	output logic wake_irq_o,
	output logic error_irq_o,
	output logic rx_irq_o
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic soft_reset_bit; // control register bit
	logic [7:0] bit_timing_second; // timing register
	logic [7:0] receive_flag_reg; // sticky flags
	logic [7:0] receive_irq_enable_reg; // flag enables
	logic [7:0] next_flags; // flag value for next edge
	logic [7:0] flag_set; // hardware set terms
	logic [7:0] flag_hold; // causes still present
	logic [7:0] flag_clr; // software clear requests
	logic aw_held; // write address captured
	logic w_held; // write data captured
	logic [7:0] aw_addr; // captured write address
	logic [7:0] w_data; // captured low byte
	logic w_lane0; // low byte lane enabled
	logic wr_fire; // register write this cycle
	logic wr_mapped; // write address decodes
	logic rd_mapped; // read address decodes
	logic [31:0] rd_word; // decoded read value
	logic recovered; // bus-off recovery seen
	logic swap_ok; // background may move forward
	logic rx_warn_cond; // receive warning cause
	logic tx_warn_cond; // transmit warning cause
	logic rx_pass_cond; // receive passive cause
	logic tx_pass_cond; // transmit passive cause
	logic bus_off_cond; // bus-off cause

	bit_timing_if timing ();

	// ------------------------------------------------------------
	// sampler and recovery counter
	// ------------------------------------------------------------
	assign timing.majority = bit_timing_second[can_rx_status_pkg::BT_MAJORITY_POS];
	assign timing.phase1 = bit_timing_second[can_rx_status_pkg::BT_PH1_LSB +: 4];
	assign timing.phase2 = bit_timing_second[can_rx_status_pkg::BT_PH2_LSB +: 3];
	assign timing.hold = soft_reset_bit;

	can_bit_sampler u_sampler (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.cfg(timing),
		.tq_tick_i(tq_tick_i),
		.can_rx_i(can_rx_i),
		.bit_o(rx_bit_o),
		.bit_valid_o(rx_bit_valid_o)
	);

	can_bus_off_recovery u_recovery (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.active_i(receive_flag_reg[can_rx_status_pkg::FLG_BUS_OFF]),
		.bit_i(rx_bit_o),
		.bit_valid_i(rx_bit_valid_o),
		.recovered_o(recovered)
	);

	// ------------------------------------------------------------
	// axi4-lite write channel
	// ------------------------------------------------------------
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;
	// address and data may arrive in either order
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 8'h00;
			w_lane0 <= 1'b0;
		end else begin
			s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_held;
			s_axi_wready <= s_axi_wvalid && !s_axi_wready && !w_held;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata[7:0];
				w_lane0 <= s_axi_wstrb[0];
			end else if (wr_fire) begin
				w_held <= 1'b0;
			end
		end
	end

	// write address decode
	always_comb begin
		if (aw_addr == can_rx_status_pkg::OFS_CONTROL) begin
			wr_mapped = 1'b1;
		end else if (aw_addr == can_rx_status_pkg::OFS_BIT_TIMING) begin
			wr_mapped = 1'b1;
		end else if (aw_addr == can_rx_status_pkg::OFS_RX_FLAG) begin
			wr_mapped = 1'b1;
		end else if (aw_addr == can_rx_status_pkg::OFS_RX_IRQ_EN) begin
			wr_mapped = 1'b1;
		end else if (aw_addr == can_rx_status_pkg::OFS_RX_ERR_CNT) begin
			wr_mapped = 1'b1;
		end else if (aw_addr == can_rx_status_pkg::OFS_TX_ERR_CNT) begin
			wr_mapped = 1'b1;
		end else begin
			wr_mapped = 1'b0;
		end
	end

	// write response, one outstanding
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= can_rx_status_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_mapped ? can_rx_status_pkg::RESP_OKAY : can_rx_status_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// control and configuration registers
	// ------------------------------------------------------------
	// soft reset bit, set after power-on so timing can be loaded
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			soft_reset_bit <= can_rx_status_pkg::SOFT_RESET_AT_POR;
		end else if (wr_fire && w_lane0 && aw_addr == can_rx_status_pkg::OFS_CONTROL) begin
			soft_reset_bit <= w_data[can_rx_status_pkg::CTRL_SOFT_RESET_POS];
		end
	end

	// timing writable only in soft reset
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bit_timing_second <= can_rx_status_pkg::BIT_TIMING_RESET;
		end else if (wr_fire && w_lane0 && soft_reset_bit && aw_addr == can_rx_status_pkg::OFS_BIT_TIMING) begin
			// invalid field values are stored as written; software must avoid them
			bit_timing_second <= w_data;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			receive_irq_enable_reg <= can_rx_status_pkg::IRQ_EN_RESET;
		end else if (soft_reset_bit) begin
			receive_irq_enable_reg <= can_rx_status_pkg::IRQ_EN_RESET;
		end else if (wr_fire && w_lane0 && aw_addr == can_rx_status_pkg::OFS_RX_IRQ_EN) begin
			receive_irq_enable_reg <= w_data;
		end
	end

	// ------------------------------------------------------------
	// flag causes
	// ------------------------------------------------------------
	// receive warning over 96
	assign rx_warn_cond = {1'b0, rx_error_count_i} > can_rx_status_pkg::WARN_LIMIT;
	assign tx_warn_cond = tx_error_count_i > can_rx_status_pkg::WARN_LIMIT;
	assign rx_pass_cond = {1'b0, rx_error_count_i} > can_rx_status_pkg::PASSIVE_LIMIT;
	assign tx_pass_cond = (tx_error_count_i > can_rx_status_pkg::PASSIVE_LIMIT)
		&& (tx_error_count_i <= can_rx_status_pkg::PASSIVE_TOP);
	assign bus_off_cond = tx_error_count_i > can_rx_status_pkg::BUS_OFF_LIMIT;
	// no swap while the foreground is full
	assign swap_ok = msg_received_i && !receive_flag_reg[can_rx_status_pkg::FLG_RX_FULL] && !soft_reset_bit;

	// set and hold terms per flag
	always_comb begin
		flag_set = 8'h00;
		flag_hold = 8'h00;
		flag_set[can_rx_status_pkg::FLG_WAKE] = sleep_mode_i && bus_activity_i;
		flag_hold[can_rx_status_pkg::FLG_WAKE] = sleep_mode_i && bus_activity_i;
		// gated by passive and bus-off flags
		flag_set[can_rx_status_pkg::FLG_RX_WARN] = rx_warn_cond
			&& !receive_flag_reg[can_rx_status_pkg::FLG_RX_PASSIVE]
			&& !receive_flag_reg[can_rx_status_pkg::FLG_TX_PASSIVE]
			&& !receive_flag_reg[can_rx_status_pkg::FLG_BUS_OFF];
		flag_hold[can_rx_status_pkg::FLG_RX_WARN] = rx_warn_cond;
		// gated by passive and bus-off flags
		flag_set[can_rx_status_pkg::FLG_TX_WARN] = tx_warn_cond
			&& !receive_flag_reg[can_rx_status_pkg::FLG_RX_PASSIVE]
			&& !receive_flag_reg[can_rx_status_pkg::FLG_TX_PASSIVE]
			&& !receive_flag_reg[can_rx_status_pkg::FLG_BUS_OFF];
		flag_hold[can_rx_status_pkg::FLG_TX_WARN] = tx_warn_cond;
		flag_set[can_rx_status_pkg::FLG_RX_PASSIVE] = rx_pass_cond
			&& !receive_flag_reg[can_rx_status_pkg::FLG_BUS_OFF];
		flag_hold[can_rx_status_pkg::FLG_RX_PASSIVE] = rx_pass_cond;
		flag_set[can_rx_status_pkg::FLG_TX_PASSIVE] = tx_pass_cond
			&& !receive_flag_reg[can_rx_status_pkg::FLG_BUS_OFF];
		flag_hold[can_rx_status_pkg::FLG_TX_PASSIVE] = tx_pass_cond;
		flag_set[can_rx_status_pkg::FLG_BUS_OFF] = bus_off_cond;
		// clear refused until recovery runs seen
		flag_hold[can_rx_status_pkg::FLG_BUS_OFF] = bus_off_cond || !recovered;
		// overrun from controller or a message into a full foreground
		flag_set[can_rx_status_pkg::FLG_OVERRUN] = overrun_i
			|| (msg_received_i && receive_flag_reg[can_rx_status_pkg::FLG_RX_FULL]);
		flag_hold[can_rx_status_pkg::FLG_OVERRUN] = flag_set[can_rx_status_pkg::FLG_OVERRUN];
		flag_set[can_rx_status_pkg::FLG_RX_FULL] = swap_ok;
		flag_hold[can_rx_status_pkg::FLG_RX_FULL] = swap_ok;
	end

	assign flag_clr = (wr_fire && w_lane0 && aw_addr == can_rx_status_pkg::OFS_RX_FLAG) ? w_data : 8'h00;

	// per-bit flag update; a set in the clearing cycle wins
	genvar fi;
	generate
		for (fi = 0; fi < 8; fi++) begin : g_flag
			assign next_flags[fi] = flag_set[fi]
				|| (receive_flag_reg[fi] && !(flag_clr[fi] && !flag_hold[fi]));
		end
	endgenerate

	// reset clears flags; held during soft reset
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			receive_flag_reg <= can_rx_status_pkg::FLAG_RESET;
		end else if (soft_reset_bit) begin
			receive_flag_reg <= can_rx_status_pkg::FLAG_RESET;
		end else begin
			receive_flag_reg <= next_flags;
		end
	end

	// ------------------------------------------------------------
	// interrupt requests and status outputs
	// ------------------------------------------------------------
	// registered to keep outputs on flops; one edge after the flags, except rx_swap_o, which rises on the edge that sets the full flag
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			wake_irq_o <= 1'b0;
			error_irq_o <= 1'b0;
			rx_irq_o <= 1'b0;
			soft_reset_o <= can_rx_status_pkg::SOFT_RESET_AT_POR;
			bus_off_o <= 1'b0;
			rx_swap_o <= 1'b0;
		end else begin
			wake_irq_o <= receive_flag_reg[can_rx_status_pkg::FLG_WAKE]
				&& receive_irq_enable_reg[can_rx_status_pkg::FLG_WAKE];
			rx_irq_o <= receive_flag_reg[can_rx_status_pkg::FLG_RX_FULL]
				&& receive_irq_enable_reg[can_rx_status_pkg::FLG_RX_FULL];
			// error request OR of enabled error-class flags
			error_irq_o <= |(receive_flag_reg & receive_irq_enable_reg & can_rx_status_pkg::ERR_CLASS_MASK);
			soft_reset_o <= soft_reset_bit;
			bus_off_o <= receive_flag_reg[can_rx_status_pkg::FLG_BUS_OFF];
			rx_swap_o <= swap_ok;
		end
	end

	// ------------------------------------------------------------
	// axi4-lite read channel
	// ------------------------------------------------------------
	// read decode; unused upper bits read zero
	always_comb begin
		rd_word = 32'h0000_0000;
		rd_mapped = 1'b1;
		if (s_axi_araddr == can_rx_status_pkg::OFS_CONTROL) begin
			rd_word[can_rx_status_pkg::CTRL_SOFT_RESET_POS] = soft_reset_bit;
		end else if (s_axi_araddr == can_rx_status_pkg::OFS_BIT_TIMING) begin
			rd_word[7:0] = bit_timing_second;
		end else if (s_axi_araddr == can_rx_status_pkg::OFS_RX_FLAG) begin
			rd_word[7:0] = receive_flag_reg;
		end else if (s_axi_araddr == can_rx_status_pkg::OFS_RX_IRQ_EN) begin
			rd_word[7:0] = receive_irq_enable_reg;
		end else if (s_axi_araddr == can_rx_status_pkg::OFS_RX_ERR_CNT) begin
			rd_word[7:0] = rx_error_count_i;
		end else if (s_axi_araddr == can_rx_status_pkg::OFS_TX_ERR_CNT) begin
			rd_word[8:0] = tx_error_count_i;
		end else begin
			rd_mapped = 1'b0;
		end
	end

	// read address accept, then data on the following edge
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= can_rx_status_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_mapped ? can_rx_status_pkg::RESP_OKAY : can_rx_status_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule : can_bit_timing_rx_status
`default_nettype wire

// ---- rtl/can_bus_off_recovery.sv ----
// counts runs of recessive bits while the node is bus-off
`timescale 1ns/1ps
`default_nettype none
module can_bus_off_recovery #(
	parameter int RUN_LEN = can_rx_status_pkg::RECESSIVE_RUN,
	parameter int RUNS = can_rx_status_pkg::RECOVERY_RUNS
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// bit stream and state
	input wire logic active_i,
	input wire logic bit_i,
	input wire logic bit_valid_i,
	// result
	output logic recovered_o
);
	logic [3:0] run_cnt; // consecutive recessive bits
	logic [7:0] run_total; // completed runs

	// count 128 runs of 11 recessive bits
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			run_cnt <= 4'h0;
			run_total <= 8'h00;
			recovered_o <= 1'b0;
		end else if (!active_i) begin
			// counting restarts on every entry to bus-off
			run_cnt <= 4'h0;
			run_total <= 8'h00;
			recovered_o <= 1'b0;
		end else if (bit_valid_i && !recovered_o) begin
			if (!bit_i) begin
				// dominant bit breaks the run
				run_cnt <= 4'h0;
			end else if (run_cnt == 4'(RUN_LEN - 1)) begin
				run_cnt <= 4'h0;
				run_total <= run_total + 8'h01;
				recovered_o <= (run_total == 8'(RUNS - 1));
			end else begin
				run_cnt <= run_cnt + 4'h1;
			end
		end
	end
endmodule : can_bus_off_recovery
`default_nettype wire

// ---- rtl/can_rx_status_pkg.sv ----
// constants for the bit timing and receiver status block
package can_rx_status_pkg;
	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_BIT_TIMING = 8'h04;
	localparam logic [7:0] OFS_RX_FLAG = 8'h08;
	localparam logic [7:0] OFS_RX_IRQ_EN = 8'h0C;
	localparam logic [7:0] OFS_RX_ERR_CNT = 8'h10;
	localparam logic [7:0] OFS_TX_ERR_CNT = 8'h14;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int BT_MAJORITY_POS = 7;
	localparam int BT_PH2_LSB = 4;
	localparam int BT_PH1_LSB = 0;
	localparam int CTRL_SOFT_RESET_POS = 0;
	localparam int FLG_WAKE = 7;
	localparam int FLG_RX_WARN = 6;
	localparam int FLG_TX_WARN = 5;
	localparam int FLG_RX_PASSIVE = 4;
	localparam int FLG_TX_PASSIVE = 3;
	localparam int FLG_BUS_OFF = 2;
	localparam int FLG_OVERRUN = 1;
	localparam int FLG_RX_FULL = 0;
	// error-class flags feeding the error interrupt
	localparam logic [7:0] ERR_CLASS_MASK = 8'h7E;
	// ------------------------------------------------------------
	// reset values and thresholds
	// ------------------------------------------------------------
	localparam logic [7:0] BIT_TIMING_RESET = 8'h00;
	localparam logic [7:0] FLAG_RESET = 8'h00;
	localparam logic [7:0] IRQ_EN_RESET = 8'h00;
	localparam logic SOFT_RESET_AT_POR = 1'b1;
	localparam logic [8:0] WARN_LIMIT = 9'h060;
	localparam logic [8:0] PASSIVE_LIMIT = 9'h07F;
	localparam logic [8:0] PASSIVE_TOP = 9'h0FF;
	localparam logic [8:0] BUS_OFF_LIMIT = 9'h0FF;
	localparam int RECESSIVE_RUN = 11;
	localparam int RECOVERY_RUNS = 128;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : can_rx_status_pkg

// ---- verification/can_bit_timing_rx_status_tb.sv ----
// self-checking bench for the bit timing and receiver status block
`timescale 1ns/1ps
`default_nettype none
module can_bit_timing_rx_status_tb;
	// ----------------------------------------
	// signals, bench state
	// ----------------------------------------
	logic ref_clk_i = 1'h0, rstn_i = 1'h0, s_axi_bready = 1'h1, s_axi_rready = 1'h1;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0, overrun_i = 1'h0;
	logic sleep_mode_i = 1'h0, bus_activity_i = 1'h0, msg_received_i = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rx_error_count_i = 8'h00;
	logic [8:0] tx_error_count_i = 9'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, can_rx_i, tq_tick_i;
	logic soft_reset_o, bus_off_o, rx_swap_o, rx_bit_o, rx_bit_valid_o, wake_irq_o, error_irq_o, rx_irq_o;
	int n_errors = 0, samples_checked = 0;
	time t0;
	typedef struct packed {logic w; logic [7:0] a, d, e; logic [1:0] r;} row_t;
	// write flag, offset, data, expected read, response; timing row keeps phase one at six quanta
	// majority with long phase one
	row_t rows [9] = '{'{1'h0, 8'h00, 8'h00, 8'h01, 2'h0}, '{1'h0, 8'h08, 8'h00, 8'h00, 2'h0},
		'{1'h1, 8'h04, 8'hA5, 8'hA5, 2'h0}, '{1'h1, 8'h0C, 8'hFF, 8'h00, 2'h0}, '{1'h1, 8'h00, 8'h00, 8'h00, 2'h0},
		'{1'h1, 8'h04, 8'h3C, 8'hA5, 2'h0}, '{1'h1, 8'h0C, 8'hFF, 8'hFF, 2'h0}, '{1'h0, 8'h10, 8'h00, 8'h00, 2'h0},
		'{1'h1, 8'h18, 8'h55, 8'h00, 2'h2}};
	can_bit_timing_rx_status can_bit_timing_rx_status_inst (.*);
	can_node_model #(.TQ_DIV(2)) can_node_model_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
		.tq_tick_o(tq_tick_i), .can_rx_o(can_rx_i));
	initial begin
		forever #20 ref_clk_i = ~ref_clk_i;
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
		logic aw_wait;
		logic w_wait;
		aw_wait = 1'h1;
		w_wait = 1'h1;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		// local flags, since the valids read back stale right after their own update
		do begin
			@(posedge ref_clk_i);
			if (aw_wait && s_axi_awready === 1'h1) begin
				aw_wait = 1'h0;
				s_axi_awvalid <= 1'h0;
			end
			if (w_wait && s_axi_wready === 1'h1) begin
				w_wait = 1'h0;
				s_axi_wvalid <= 1'h0;
			end
		end while (aw_wait || w_wait);
		// bready stays high, so the response is taken at the edge it is seen
		while (s_axi_bvalid !== 1'h1) @(posedge ref_clk_i);
		chk(32'(s_axi_bresp), 32'(r));
	endtask : wr
	// rready stays high, so data and response are taken at the handshake edge
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] r = 2'h0);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do @(posedge ref_clk_i); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		do @(posedge ref_clk_i); while (s_axi_rvalid !== 1'h1);
		chk(32'(s_axi_rresp), 32'(r));
		chk(s_axi_rdata, {24'h0, e});
	endtask : rd
	task automatic msg;
		msg_received_i <= 1'h1;
		@(posedge ref_clk_i);
		msg_received_i <= 1'h0;
		@(posedge ref_clk_i);
	endtask : msg
	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : conclude
	// hang guard, well beyond the bus-off recovery span
	initial begin
		repeat (50000) @(posedge ref_clk_i);
		n_errors++;
		conclude();
	end
	initial begin
		repeat (6) @(posedge ref_clk_i);
		rstn_i <= 1'h1;
		@(posedge ref_clk_i);
		foreach (rows[i]) begin
			if (rows[i].w) wr(rows[i].a, rows[i].d, rows[i].r);
			rd(rows[i].a, rows[i].e, rows[i].r);
		end
		rx_error_count_i <= 8'h61;
		rd(8'h08, 8'h40);
		chk(32'(error_irq_o), 32'h1);
		rx_error_count_i <= 8'h80;
		rd(8'h08, 8'h50);
		tx_error_count_i <= 9'h064;
		rd(8'h08, 8'h50);
		tx_error_count_i <= 9'h080;
		rd(8'h08, 8'h58);
		wr(8'h08, 8'hFF);
		rd(8'h08, 8'h58);
		rx_error_count_i <= 8'h00;
		tx_error_count_i <= 9'h000;
		wr(8'h08, 8'h00);
		rd(8'h08, 8'h58);
		wr(8'h08, 8'hFF);
		rd(8'h08, 8'h00);
		chk(32'(error_irq_o), 32'h0);
		tx_error_count_i <= 9'h12C;
		rd(8'h08, 8'h24);
		chk(32'(bus_off_o), 32'h1);
		tx_error_count_i <= 9'h000;
		wr(8'h08, 8'hFF);
		rd(8'h08, 8'h04);
		do @(posedge ref_clk_i); while (rx_bit_valid_o !== 1'h1);
		t0 = $time;
		do @(posedge ref_clk_i); while (rx_bit_valid_o !== 1'h1);
		chk(32'($time - t0), 32'h320);
		chk(32'(rx_bit_o), 32'h1);
		repeat (1420) begin
			do @(posedge ref_clk_i); while (rx_bit_valid_o !== 1'h1);
		end
		wr(8'h08, 8'h04);
		rd(8'h08, 8'h00);
		msg();
		chk(32'(rx_swap_o), 32'h1);
		rd(8'h08, 8'h01);
		chk(32'(rx_irq_o), 32'h1);
		msg();
		chk(32'(rx_swap_o), 32'h0);
		rd(8'h08, 8'h03);
		chk(32'(error_irq_o), 32'h1);
		wr(8'h08, 8'h03);
		rd(8'h08, 8'h00);
		sleep_mode_i <= 1'h1;
		bus_activity_i <= 1'h1;
		@(posedge ref_clk_i);
		bus_activity_i <= 1'h0;
		sleep_mode_i <= 1'h0;
		rd(8'h08, 8'h80);
		chk(32'(wake_irq_o), 32'h1);
		wr(8'h00, 8'h01);
		msg();
		rd(8'h08, 8'h00);
		rd(8'h0C, 8'h00);
		chk(32'(wake_irq_o), 32'h0);
		chk(32'(soft_reset_o), 32'h1);
		conclude();
	end
endmodule : can_bit_timing_rx_status_tb
bind can_bit_timing_rx_status can_status_props can_status_props_inst (.*);
`default_nettype wire

// ---- verification/can_node_model.sv ----
// far-side node model: quantum ticks and an idle recessive bus
`timescale 1ns/1ps
`default_nettype none
module can_node_model #(
	parameter int TQ_DIV = 2 // clocks per time quantum
) (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// bus side
	output logic tq_tick_o,
	output logic can_rx_o
);
	int cnt; // clocks into the quantum
	// quantum pulse every TQ_DIV clocks
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt <= 0;
			tq_tick_o <= 1'h0;
		end else begin
			cnt <= (cnt == TQ_DIV - 1) ? 0 : cnt + 1;
			tq_tick_o <= (cnt == TQ_DIV - 1);
		end
	end
	// silent nodes leave the bus recessive
	assign can_rx_o = 1'h1;
endmodule : can_node_model
`default_nettype wire

// ---- verification/can_status_props.sv ----
// port assertions for the bit timing and receiver status block
`timescale 1ns/1ps
`default_nettype none
module can_status_props (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// bus handshakes
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// controller events
	input wire logic msg_received_i,
	input wire logic [8:0] tx_error_count_i,
	// block outputs
	input wire logic soft_reset_o,
	input wire logic bus_off_o,
	input wire logic rx_swap_o,
	input wire logic rx_bit_valid_o,
	input wire logic error_irq_o,
	input wire logic rx_irq_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);
	// three cycles deep, so the one-cycle lag of soft_reset_o is covered
	sequence soft_held;
		soft_reset_o [*3];
	endsequence
	// bus-off count seen on two edges in normal operation
	sequence tx_over;
		(!soft_reset_o && tx_error_count_i[8]) [*2];
	endsequence
	irq_quiet_a: assert property (soft_held |-> !error_irq_o && !rx_irq_o)
		else $error("interrupt while in soft reset");
	sampler_idle_a: assert property (soft_held |-> !rx_bit_valid_o)
		else $error("bit decided while in soft reset");
	bus_off_set_a: assert property (tx_over |-> ##[0:2] bus_off_o)
		else $error("bus-off not raised");
	// only a write or a soft reset may drop bus-off
	bus_off_clear_a: assert property ($fell(bus_off_o) |-> soft_reset_o || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
		else $error("bus-off dropped without a clear");
	swap_cause_a: assert property (rx_swap_o |-> $past(msg_received_i))
		else $error("swap without a message");
	rx_irq_cause_a: assert property ($rose(rx_irq_o) |-> $past(rx_swap_o) || $past(s_axi_bvalid))
		else $error("receive request without cause");
	ready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready longer than one cycle");
	rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("rvalid dropped early");
	rvalid_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("rvalid held after handshake");
endmodule : can_status_props
`default_nettype wire
